// *** design/ssp_consts.vh ***
// Purpose: Shared constants of the status and service request block.
// Assumes: AXI4-Lite register access, one 10 MHz clock.
// Notes:   Offsets are byte addresses; each register takes one word.
//
// Operation
// - Call-connected is call group condition bit 3.
// - Falling filter latches call ended or dropped.
// - Call summary drives operation condition bit 8.
// - Default filters pass rising, block falling changes.
// - Serial poll reads request-service flag at bit 6.
// - Call event query returns contents, then clears.
// - Operation event query clears; re-arms on summary.
// - Clear-status clears every event register at once.
// - Standard event error bits 5,4,3,2 with enable.
// - Calibration auto-zero bit 4, voltmeter bit 3.
// - Serial poll clears bit 6 only.
// - Master summary ORs enabled bits except six.
// - Service enable ignores bit 6; zero disables.
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SSP_OFF_STB        12'h000
`define SSP_OFF_POLL       12'h004
`define SSP_OFF_SRE        12'h008
`define SSP_OFF_CLS        12'h00C
`define SSP_OFF_ESR        12'h010
`define SSP_OFF_ESE        12'h014
`define SSP_OFF_IRQ_STAT   12'h018
`define SSP_OFF_IRQ_MASK   12'h01C
`define SSP_OFF_GRP_BASE   12'h040
`define SSP_GRP_STRIDE     12'h020
`define SSP_GRP_COND       5'h00
`define SSP_GRP_PTR        5'h04
`define SSP_GRP_NTR        5'h08
`define SSP_GRP_EVEN       5'h0C
`define SSP_GRP_ENAB       5'h10

// ****************************************************************
// Group indices and field positions
// ****************************************************************
`define SSP_GRP_CALL       0
`define SSP_GRP_OPER       1
`define SSP_GRP_QUES       2
`define SSP_GRP_CAL        3
`define SSP_NUM_GRP        4
`define SSP_CALL_CONN_BIT  3
`define SSP_OPER_CALL_BIT  8
`define SSP_QUES_CAL_BIT   8
`define SSP_CAL_TXZ_BIT    4
`define SSP_CAL_VM_BIT     3
`define SSP_ESR_CMD_BIT    5
`define SSP_ESR_EXE_BIT    4
`define SSP_ESR_DDE_BIT    3
`define SSP_ESR_QRY_BIT    2
`define SSP_STB_QUES_BIT   3
`define SSP_STB_MAV_BIT    4
`define SSP_STB_ESB_BIT    5
`define SSP_STB_RQS_BIT    6
`define SSP_STB_OPER_BIT   7
`define SSP_IRQ_RQS_BIT    0
`define SSP_IRQ_ERR_BIT    1
`define SSP_IRQ_DROP_BIT   2

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define SSP_PTR_RST        16'hFFFF
`define SSP_NTR_RST        16'h0000
`define SSP_ENAB_RST       16'h0000
`define SSP_SRE_MASK       8'hBF
`define SSP_ESR_ERR_MASK   8'h3C
`define SSP_RESP_OKAY      2'h0
`define SSP_RESP_SLVERR    2'h2

`endif

// *** design/ssp_sync.v ***
// Purpose: Two-flop synchroniser for asynchronous condition pins.
// Assumes: Each bit is an independent level.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none

module ssp_sync #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_q
);

    reg [WIDTH-1:0] meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule

`default_nettype wire

// *** design/ssp_group.v ***
// Purpose: One status register group: filters, event latch and summary.
// Assumes: Condition levels are already in the clock domain.
// Notes:   A new transition wins over a clear in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module ssp_group #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Condition and configuration
    input  wire [WIDTH-1:0] cond,
    input  wire [WIDTH-1:0] ptr,
    input  wire [WIDTH-1:0] ntr,
    input  wire [WIDTH-1:0] enab,
    // Clears
    input  wire             ev_rd_clr,
    input  wire             cls,
    // Results
    output reg  [WIDTH-1:0] event_q,
    output reg              summary_q
);

    reg  [WIDTH-1:0] prev_q;
    wire [WIDTH-1:0] rise;
    wire [WIDTH-1:0] fall;

    assign rise = cond & ~prev_q & ptr;
    assign fall = ~cond & prev_q & ntr;

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_q    <= {WIDTH{1'b0}};
            event_q   <= {WIDTH{1'b0}};
            summary_q <= 1'b0;
        end else begin
            prev_q <= cond;
            event_q <= ((ev_rd_clr | cls) ? {WIDTH{1'b0}} : event_q) | rise | fall;
            summary_q <= |(event_q & enab);
        end
    end

endmodule

`default_nettype wire

// *** design/ssp_top.v ***
// Purpose: Status reporting and service request block with AXI4-Lite access.
// Assumes: Condition pins are asynchronous; event pulses share aclk.
// Notes:   Reads of event and interrupt status registers clear them; a poll read clears bit 6 only.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"

module ssp_top #(
    parameter GW = 16
) (
    // Clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // AXI4-Lite write address
    input  wire [11:0]   s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    // AXI4-Lite read address
    input  wire [11:0]   s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // Asynchronous condition pins
    input  wire [GW-1:0] call_cond_pins,
    input  wire [GW-1:0] oper_cond_pins,
    input  wire [GW-1:0] ques_cond_pins,
    input  wire [GW-1:0] cal_cond_pins,
    // Same-clock event sources
    input  wire [7:0]    std_event_set,
    input  wire          msg_avail,
    input  wire [2:0]    stb_aux,
    // Service request and interrupt
    output reg           srq_q,
    output reg           irq_q
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam NG = `SSP_NUM_GRP;

    wire [NG*GW-1:0] pins_sync;
    wire [NG*GW-1:0] grp_cond;
    wire [NG*GW-1:0] grp_event;
    wire [NG-1:0]    grp_summ;
    reg  [NG*GW-1:0] ptr_q;
    reg  [NG*GW-1:0] ntr_q;
    reg  [NG*GW-1:0] enab_q;
    reg  [NG-1:0]    ev_clr_q;
    reg              cls_q;
    reg  [7:0]       sre_q;
    reg  [7:0]       esr_q;
    reg  [7:0]       ese_q;
    reg              esb_q;
    reg  [7:0]       stb_q;
    reg              mss_q;
    reg              mss_prev_q;
    reg              rqs_q;
    reg  [2:0]       irq_stat_q;
    reg  [2:0]       irq_mask_q;
    reg  [31:0]      rd_data;
    reg              rd_ok;
    reg              wr_ok;
    wire             wr_fire;
    wire             rd_fire;
    wire [11:0]      wa;
    wire [11:0]      ra;
    wire [2:0]       wgi;
    wire [2:0]       rgi;
    wire             rqs_set;
    wire             poll_clr;
    wire [2:0]       irq_set;
    wire             irq_clr;
    wire             esr_clr;
    integer          i;

    // ****************************************************************
    // Condition pins and group wiring
    // ****************************************************************
    ssp_sync #(
        .WIDTH(NG*GW)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .async_in({cal_cond_pins, ques_cond_pins, oper_cond_pins, call_cond_pins}),
        .sync_q  (pins_sync)
    );

    assign grp_cond[`SSP_GRP_CALL*GW +: GW] = pins_sync[`SSP_GRP_CALL*GW +: GW];
    // call summary into operation bit 8
    assign grp_cond[`SSP_GRP_OPER*GW +: GW] =
        {pins_sync[`SSP_GRP_OPER*GW+`SSP_OPER_CALL_BIT+1 +: GW-`SSP_OPER_CALL_BIT-1],
         grp_summ[`SSP_GRP_CALL],
         pins_sync[`SSP_GRP_OPER*GW +: `SSP_OPER_CALL_BIT]};
    assign grp_cond[`SSP_GRP_QUES*GW +: GW] =
        {pins_sync[`SSP_GRP_QUES*GW+`SSP_QUES_CAL_BIT+1 +: GW-`SSP_QUES_CAL_BIT-1],
         grp_summ[`SSP_GRP_CAL],
         pins_sync[`SSP_GRP_QUES*GW +: `SSP_QUES_CAL_BIT]};
    assign grp_cond[`SSP_GRP_CAL*GW +: GW] = pins_sync[`SSP_GRP_CAL*GW +: GW];

    genvar g;
    generate
        for (g = 0; g < NG; g = g + 1) begin : gen_grp
            ssp_group #(
                .WIDTH(GW)
            ) u_grp (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .cond     (grp_cond[g*GW +: GW]),
                .ptr      (ptr_q[g*GW +: GW]),
                .ntr      (ntr_q[g*GW +: GW]),
                .enab     (enab_q[g*GW +: GW]),
                .ev_rd_clr(ev_clr_q[g]),
                .cls      (cls_q),
                .event_q  (grp_event[g*GW +: GW]),
                .summary_q(grp_summ[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign wa      = {s_axi_awaddr[11:2], 2'b00};
    assign ra      = {s_axi_araddr[11:2], 2'b00};
    // The group index is the 32-byte slot counted from the window base.
    assign wgi     = wa[7:5] - 3'd2;
    assign rgi     = ra[7:5] - 3'd2;

    function [GW-1:0] merge;
        input [GW-1:0] old;
        input [31:0]   wd;
        input [3:0]    ws;
        begin
            merge = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // Group registers sit in a window of 0x40 to 0xBF.
    always @* begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (ra[11:8] == 4'h0 && ra[7:6] != 2'b00 && ra[7:5] < 3'd6 && ra[4:0] <= 5'h10) begin
            case (ra[4:0])
                `SSP_GRP_COND: rd_data[GW-1:0] = grp_cond[rgi[1:0]*GW +: GW];
                `SSP_GRP_PTR:  rd_data[GW-1:0] = ptr_q[rgi[1:0]*GW +: GW];
                `SSP_GRP_NTR:  rd_data[GW-1:0] = ntr_q[rgi[1:0]*GW +: GW];
                `SSP_GRP_EVEN: rd_data[GW-1:0] = grp_event[rgi[1:0]*GW +: GW];
                `SSP_GRP_ENAB: rd_data[GW-1:0] = enab_q[rgi[1:0]*GW +: GW];
                default:       rd_ok = 1'b0;
            endcase
        end else begin
            case (ra)
                `SSP_OFF_STB:      rd_data[7:0] = {stb_q[7], mss_q, stb_q[5:0]};
                `SSP_OFF_POLL:     rd_data[7:0] = {stb_q[7], rqs_q, stb_q[5:0]};
                `SSP_OFF_SRE:      rd_data[7:0] = sre_q;
                `SSP_OFF_ESR:      rd_data[7:0] = esr_q;
                `SSP_OFF_ESE:      rd_data[7:0] = ese_q;
                `SSP_OFF_IRQ_STAT: rd_data[2:0] = irq_stat_q;
                `SSP_OFF_IRQ_MASK: rd_data[2:0] = irq_mask_q;
                default:           rd_ok = 1'b0;
            endcase
        end
    end

    always @* begin
        wr_ok = 1'b1;
        if (wa[11:8] == 4'h0 && wa[7:6] != 2'b00 && wa[7:5] < 3'd6) begin
            wr_ok = (wa[4:0] == `SSP_GRP_PTR) || (wa[4:0] == `SSP_GRP_NTR) ||
                    (wa[4:0] == `SSP_GRP_ENAB);
        end else begin
            case (wa)
                `SSP_OFF_SRE, `SSP_OFF_CLS, `SSP_OFF_ESE, `SSP_OFF_IRQ_MASK: wr_ok = 1'b1;
                default: wr_ok = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite handshakes
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SSP_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `SSP_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            // Both channels are taken at one edge, so each waits for the other's valid.
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Configuration registers and clear strobes
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            ptr_q      <= {NG{`SSP_PTR_RST}};
            ntr_q      <= {NG{`SSP_NTR_RST}};
            enab_q     <= {NG{`SSP_ENAB_RST}};
            sre_q      <= 8'h00;
            ese_q      <= 8'h00;
            irq_mask_q <= 3'h0;
            cls_q      <= 1'b0;
            ev_clr_q   <= {NG{1'b0}};
        end else begin
            cls_q    <= wr_fire & (wa == `SSP_OFF_CLS);
            ev_clr_q <= {NG{1'b0}};
            if (rd_fire && rd_ok && ra[7:6] != 2'b00 && ra[4:0] == `SSP_GRP_EVEN) begin
                ev_clr_q[rgi[1:0]] <= 1'b1;
            end
            if (wr_fire && wr_ok) begin
                if (wa[7:6] != 2'b00) begin
                    case (wa[4:0])
                        `SSP_GRP_PTR:
                            ptr_q[wgi[1:0]*GW +: GW] <=
                                merge(ptr_q[wgi[1:0]*GW +: GW], s_axi_wdata, s_axi_wstrb);
                        `SSP_GRP_NTR:
                            ntr_q[wgi[1:0]*GW +: GW] <=
                                merge(ntr_q[wgi[1:0]*GW +: GW], s_axi_wdata, s_axi_wstrb);
                        `SSP_GRP_ENAB:
                            enab_q[wgi[1:0]*GW +: GW] <=
                                merge(enab_q[wgi[1:0]*GW +: GW], s_axi_wdata, s_axi_wstrb);
                        default: ;
                    endcase
                end else begin
                    case (wa)
                        `SSP_OFF_SRE:
                            if (s_axi_wstrb[0]) sre_q <= s_axi_wdata[7:0] & `SSP_SRE_MASK;
                        `SSP_OFF_ESE:
                            if (s_axi_wstrb[0]) ese_q <= s_axi_wdata[7:0];
                        `SSP_OFF_IRQ_MASK:
                            if (s_axi_wstrb[0]) irq_mask_q <= s_axi_wdata[2:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Standard event register and status byte
    // ****************************************************************
    assign esr_clr  = rd_fire & (ra == `SSP_OFF_ESR);
    assign poll_clr = rd_fire & (ra == `SSP_OFF_POLL);
    // The flag sets on a rising master summary only, so a poll is not undone.
    assign rqs_set  = mss_q & ~mss_prev_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            esr_q      <= 8'h00;
            esb_q      <= 1'b0;
            stb_q      <= 8'h00;
            mss_q      <= 1'b0;
            mss_prev_q <= 1'b0;
            rqs_q      <= 1'b0;
            srq_q      <= 1'b0;
        end else begin
            esr_q <= ((esr_clr | cls_q) ? 8'h00 : esr_q) | std_event_set;
            esb_q <= |(esr_q & ese_q);
            stb_q <= {grp_summ[`SSP_GRP_OPER], 1'b0, esb_q, msg_avail,
                      grp_summ[`SSP_GRP_QUES], stb_aux};
            mss_q      <= |(stb_q & sre_q & `SSP_SRE_MASK);
            mss_prev_q <= mss_q;
            rqs_q <= (poll_clr ? 1'b0 : rqs_q) | rqs_set;
            srq_q <= (poll_clr ? 1'b0 : rqs_q) | rqs_set;
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    assign irq_set = {grp_event[`SSP_GRP_CALL*GW+`SSP_CALL_CONN_BIT] &
                      ntr_q[`SSP_GRP_CALL*GW+`SSP_CALL_CONN_BIT],
                      |(std_event_set & `SSP_ESR_ERR_MASK),
                      rqs_set};
    assign irq_clr = rd_fire & (ra == `SSP_OFF_IRQ_STAT);

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 3'h0;
            irq_q      <= 1'b0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                irq_stat_q[i] <= (irq_clr ? 1'b0 : irq_stat_q[i]) | irq_set[i];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule

`default_nettype wire

// *** verif/ssp_assertions.sv ***
// Purpose: Port-level checks of the register bus and the service request line.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Attached to every ssp_top instance by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none

module ssp_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Request lines
    input wire logic        srq_q,
    input wire logic        irq_q
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("write channels not taken together");
    chk_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid && s_axi_wvalid))
        else $error("write taken without both valids");
    chk_b_after_aw: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    chk_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    chk_r_after_ar: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not retired");
    chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read ready longer than one cycle");
    chk_poll_clear: assert property (
        s_axi_arready && s_axi_araddr == 12'h004 |-> ##[1:3] !srq_q)
        else $error("service request kept after serial poll");
    chk_reset_quiet: assert property ($rose(aresetn) |-> !srq_q && !irq_q)
        else $error("request lines high after reset");

    cov_srq: cover property ($rose(srq_q));
    cov_irq: cover property ($rose(irq_q));
    cov_poll: cover property (s_axi_arready && s_axi_araddr == 12'h004);
endmodule

bind ssp_top ssp_chk i_chk (.*);
`default_nettype wire

// *** verif/ssp_host.sv ***
// Purpose: Bus controller model, register access over AXI4-Lite.
// Assumes: The slave answers in its own time; only the bounds end a wait.
// Notes:   Raises hung when an answer never comes.
`timescale 1ns/10ps
`default_nettype none

module ssp_host (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output var  logic [11:0] s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // Read channels
    output var  logic [11:0] s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready,
    // Wait overrun
    output var  logic        hung
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
             s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;

    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1 && ++n < 60);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && ++n < 120);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) hung <= 1'b1;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++n < 60);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && ++n < 120);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) hung <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the status and service request block.
// Assumes: 10 MHz clock, reset held low for four cycles.
// Notes:   Register table first, then the call-drop, clear and reset cases.
`timescale 1ns/10ps
`default_nettype none

module tb;
    typedef struct packed {
        logic [1:0]  k;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic [1:0]  r;
    } ssp_row_t;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] call_cond_pins = 16'h0000, cal_cond_pins = 16'h0000;
    logic [15:0] oper_cond_pins = 16'h0000, ques_cond_pins = 16'h0000;
    logic [7:0]  std_event_set = 8'h00;
    logic [2:0]  stb_aux = 3'h0;
    logic        msg_avail = 1'b0, srq_q, irq_q, hung;
    int          num_errors = 0, n_compared = 0;
    // Kind 0 reads, 1 writes then reads back, 2 writes and checks the response.
    ssp_row_t    rows [8] = '{
        '{2'h0, 12'h044, 32'h0, 32'h0000FFFF, 2'h0}, '{2'h0, 12'h068, 32'h0, 32'h0, 2'h0},
        '{2'h0, 12'h070, 32'h0, 32'h0, 2'h0}, '{2'h1, 12'h008, 32'hFF, 32'hBF, 2'h0},
        '{2'h1, 12'h008, 32'h0, 32'h0, 2'h0}, '{2'h1, 12'h014, 32'h3C, 32'h3C, 2'h0},
        '{2'h2, 12'h000, 32'h1, 32'h0, 2'h2}, '{2'h0, 12'h300, 32'h0, 32'h0, 2'h2}};
    logic [43:0] cfg [6] = '{{12'h048, 32'h8}, {12'h044, 32'h0}, {12'h050, 32'h8},
                             {12'h070, 32'h100}, {12'h008, 32'h80}, {12'h01C, 32'h1}};

    always #50 aclk = ~aclk;

    ssp_top i_dut (.*);
    ssp_host i_host (.*);

    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t word %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t line %b expected %b", $time, g, e);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic [1:0] xr = 2'h0);
        logic [31:0] d;
        logic [1:0]  r;
        i_host.rd(a, d, r);
        chk_w(d, x);
        chk_w({30'h0, r}, {30'h0, xr});
    endtask

    task automatic wrc(input logic [11:0] a, input logic [31:0] d);
        i_host.wr(a, d, rsp);
        chk_w({30'h0, rsp}, 32'h0);
    endtask

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge hung) begin
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].k != 2'h0) i_host.wr(rows[i].a, rows[i].d, rsp);
            if (rows[i].k != 2'h0) chk_w({30'h0, rsp}, {30'h0, rows[i].r});
            if (rows[i].k != 2'h2) rd_chk(rows[i].a, rows[i].x, rows[i].r);
        end
        foreach (cfg[i]) wrc(cfg[i][43:32], cfg[i][31:0]);
        @(posedge aclk) call_cond_pins <= 16'h0008;
        repeat (16) @(posedge aclk);
        rd_chk(12'h040, 32'h8);
        chk_b(srq_q, 1'b0);
        @(posedge aclk) call_cond_pins <= 16'h0000;
        for (int n = 0; n < 40 && srq_q !== 1'b1; n++) @(posedge aclk);
        chk_b(srq_q, 1'b1);
        repeat (4) @(posedge aclk);
        chk_b(irq_q, 1'b1);
        rd_chk(12'h000, 32'hC0);
        rd_chk(12'h004, 32'hC0);
        chk_b(srq_q, 1'b0);
        rd_chk(12'h004, 32'h80);
        rd_chk(12'h018, 32'h5);
        repeat (3) @(posedge aclk);
        chk_b(irq_q, 1'b0);
        rd_chk(12'h04C, 32'h8);
        rd_chk(12'h04C, 32'h0);
        rd_chk(12'h06C, 32'h100);
        rd_chk(12'h06C, 32'h0);
        repeat (8) @(posedge aclk);
        rd_chk(12'h000, 32'h0);
        chk_b(srq_q, 1'b0);
        @(posedge aclk) std_event_set <= 8'h3C;
        cal_cond_pins <= 16'h0018;
        @(posedge aclk) std_event_set <= 8'h00;
        repeat (8) @(posedge aclk);
        rd_chk(12'h000, 32'h20);
        rd_chk(12'h010, 32'h3C);
        rd_chk(12'h0A0, 32'h18);
        wrc(12'h008, 32'h10);
        msg_avail <= 1'b1;
        stb_aux <= 3'h5;
        repeat (4) @(posedge aclk);
        rd_chk(12'h000, 32'h55);
        msg_avail <= 1'b0;
        stb_aux <= 3'h0;
        @(posedge aclk) std_event_set <= 8'h20;
        @(posedge aclk) std_event_set <= 8'h00;
        wrc(12'h00C, 32'h0);
        repeat (4) @(posedge aclk);
        rd_chk(12'h010, 32'h0);
        rd_chk(12'h0AC, 32'h0);
        @(posedge aclk) aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk_b(srq_q, 1'b0);
        chk_b(irq_q, 1'b0);
        rd_chk(12'h008, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
